// >>> hw/bfsp_cfg.svh
// Timing and framing constants for the byte-paced serial host port.
// Assumes a 10 MHz clock; every cycle count is derived from a time and the rate.
`ifndef BFSP_CFG_SVH
`define BFSP_CFG_SVH
`define BFSP_CLK_HZ 10000000
`define BFSP_BAUD 9600
`define BFSP_DATA_BITS 8
`define BFSP_BIT_CYC (`BFSP_CLK_HZ / `BFSP_BAUD)
`define BFSP_MS_CYC (`BFSP_CLK_HZ / 1000)
`define BFSP_STROBE_NS 500
`define BFSP_STROBE_CYC ((`BFSP_STROBE_NS * (`BFSP_CLK_HZ / 1000000) + 999) / 1000)
`define BFSP_ACK_DELAY_MS 500
`define BFSP_GAP_MS 20
`define BFSP_CTS_LEAD_MS 5
`endif

// >>> hw/bfsp_pkg.sv
// Types used by the device end and the testbench of the byte-paced serial host port.
// Constants live in bfsp_cfg.svh.
package bfsp_pkg;
  typedef logic [7:0] bfsp_byte_t;
  typedef enum logic [2:0] {
    BFSP_IDLE, BFSP_WAKE, BFSP_WAIT_ACK, BFSP_SEND, BFSP_GAP
  } bfsp_tx_e;
endpackage

// >>> hw/bfsp_link_if.sv
// Wires between the device end and the host end of the serial port.
// All handshakes are active low; data lines idle high.
`timescale 1ns/1ps
interface bfsp_link_if;
  logic dev_tx;
  logic host_tx;
  logic dev_send_request_n;
  logic host_rx_ready_n;
  logic dev_net_ready_n;
  logic time_strobe_n;
  logic mode_byte_paced;
  modport dev (output dev_tx, dev_send_request_n, dev_net_ready_n,
    input host_tx, host_rx_ready_n, time_strobe_n, mode_byte_paced);
  modport host (input dev_tx, dev_send_request_n, dev_net_ready_n,
    output host_tx, host_rx_ready_n, time_strobe_n, mode_byte_paced);
endinterface

// >>> hw/bfsp_device.sv
// Device end: paced serial transmitter, receiver, wake and ready lines.
// Assumes link inputs synchronous to clock; one 10 MHz clock.
`timescale 1ns/1ps
`include "bfsp_cfg.svh"
module bfsp_device #(
  parameter int BIT_CYC = `BFSP_BIT_CYC,
  parameter int ACK_DELAY_CYC = `BFSP_ACK_DELAY_MS * `BFSP_MS_CYC,
  parameter int GAP_CYC = `BFSP_GAP_MS * `BFSP_MS_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link
  bfsp_link_if.dev link,
  // Outgoing bytes from the device core
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // Incoming bytes to the device core
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err,
  // Core status
  input wire logic net_joined,
  input wire logic net_buf_free,
  output logic time_request
);
  localparam int CW = 24;
  localparam int STB = `BFSP_STROBE_CYC;
  localparam int HALF = BIT_CYC / 2;

  // Two-entry buffer between core and the serial shifter
  logic [8:0] buf_q [2];
  logic [1:0] buf_cnt;
  logic buf_wr;
  logic buf_rd;
  logic buf_head;
  wire logic [8:0] buf_out = buf_q[buf_head];
  assign buf_wr = tx_valid && tx_ready;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_cnt <= 2'h0;
      buf_head <= 1'b0;
      tx_ready <= 1'b0;
      buf_q[0] <= 9'h000;
      buf_q[1] <= 9'h000;
    end else begin
      if (buf_wr) begin
        buf_q[buf_head ^ buf_cnt[0]] <= {tx_last, tx_data};
      end
      if (buf_rd) begin
        buf_head <= ~buf_head;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
      tx_ready <= (buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd}) < 2'h2;
    end
  end

  // Host ready sampled and high-pulse width measured
  wire logic cts_low = ~link.host_rx_ready_n;
  logic [CW-1:0] hi_cnt;
  logic ack_seen;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt <= '0;
    end else if (cts_low) begin
      hi_cnt <= '0;
    end else if (hi_cnt < CW'(STB)) begin
      hi_cnt <= hi_cnt + CW'(1);
    end
  end

  // Transmit sequencer
  bfsp_pkg::bfsp_tx_e st;
  logic [CW-1:0] tcnt;
  logic [3:0] bit_idx;
  logic [9:0] shreg;
  logic last_byte;
  wire logic paced = link.mode_byte_paced;
  wire logic bit_end = tcnt == CW'(BIT_CYC - 1);
  wire logic frame_end = bit_end && bit_idx == 4'h9;
  assign buf_rd = (st == bfsp_pkg::BFSP_WAIT_ACK) && cts_low && buf_cnt != 2'h0 && ack_seen;
  // Acknowledge pulse is latched wherever it lands, even mid-stop-bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= bfsp_pkg::BFSP_IDLE;
      tcnt <= '0;
      bit_idx <= 4'h0;
      shreg <= 10'h3ff;
      last_byte <= 1'b0;
      ack_seen <= 1'b0;
      link.dev_tx <= 1'b1;
      link.dev_send_request_n <= 1'b1;
    end else begin
      if (hi_cnt >= CW'(STB)) begin
        ack_seen <= 1'b1;
      end
      unique case (st)
        bfsp_pkg::BFSP_IDLE: begin
          ack_seen <= 1'b1;
          if (buf_cnt != 2'h0) begin
            st <= bfsp_pkg::BFSP_WAKE;
            tcnt <= '0;
            link.dev_send_request_n <= 1'b0;
          end
        end
        bfsp_pkg::BFSP_WAKE: begin
          tcnt <= tcnt + CW'(1);
          // Release on host ready or acknowledge timeout
          if (cts_low || tcnt >= CW'(ACK_DELAY_CYC - 1)) begin
            link.dev_send_request_n <= 1'b1;
            st <= bfsp_pkg::BFSP_WAIT_ACK;
          end
        end
        bfsp_pkg::BFSP_WAIT_ACK: begin
          if (buf_rd) begin
            // Pacing needs a fresh high pulse; otherwise free-running
            ack_seen <= ~paced;
            shreg <= {1'b1, buf_out[7:0], 1'b0};
            last_byte <= buf_out[8];
            bit_idx <= 4'h0;
            tcnt <= '0;
            st <= bfsp_pkg::BFSP_SEND;
          end
        end
        bfsp_pkg::BFSP_SEND: begin
          link.dev_tx <= shreg[0];
          tcnt <= bit_end ? '0 : tcnt + CW'(1);
          if (bit_end) begin
            shreg <= {1'b1, shreg[9:1]};
            bit_idx <= bit_idx + 4'h1;
          end
          if (frame_end) begin
            tcnt <= '0;
            st <= last_byte ? bfsp_pkg::BFSP_GAP : bfsp_pkg::BFSP_WAIT_ACK;
          end
        end
        bfsp_pkg::BFSP_GAP: begin
          tcnt <= tcnt + CW'(1);
          if (tcnt >= CW'(GAP_CYC - 1)) begin
            st <= bfsp_pkg::BFSP_IDLE;
          end
        end
      endcase
    end
  end

  // Receiver: mid-bit sampling tolerates rate error
  logic [CW-1:0] rcnt;
  logic [3:0] ridx;
  logic [7:0] rsh;
  logic rbusy;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rcnt <= '0;
      ridx <= 4'h0;
      rsh <= 8'h00;
      rbusy <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
      if (!rbusy) begin
        if (!link.host_tx) begin
          rbusy <= 1'b1;
          rcnt <= CW'(HALF);
          ridx <= 4'h0;
        end
      end else if (rcnt == CW'(BIT_CYC - 1)) begin
        rcnt <= '0;
        ridx <= ridx + 4'h1;
        if (ridx >= 4'h1 && ridx <= 4'h8) begin
          rsh <= {link.host_tx, rsh[7:1]};
        end
        if (ridx == 4'h9) begin
          rbusy <= 1'b0;
          rx_data <= rsh;
          rx_valid <= link.host_tx;
          rx_frame_err <= ~link.host_tx;
        end
      end else begin
        rcnt <= rcnt + CW'(1);
      end
    end
  end

  // Network-ready and timestamp strobe
  logic [CW-1:0] tcnt_time;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.dev_net_ready_n <= 1'b1;
      tcnt_time <= '0;
      time_request <= 1'b0;
    end else begin
      link.dev_net_ready_n <= ~(net_joined && net_buf_free);
      time_request <= 1'b0;
      if (link.time_strobe_n) begin
        tcnt_time <= '0;
      end else if (tcnt_time < CW'(STB)) begin
        tcnt_time <= tcnt_time + CW'(1);
        time_request <= tcnt_time == CW'(STB - 1);
      end
    end
  end
endmodule

// >>> hw/bfsp_host.sv
// Host end: receives paced bytes, acknowledges each, sends its own bytes.
// Assumes link inputs synchronous to clock; one 10 MHz clock.
`timescale 1ns/1ps
`include "bfsp_cfg.svh"
module bfsp_host #(
  parameter int BIT_CYC = `BFSP_BIT_CYC,
  parameter int GAP_CYC = `BFSP_GAP_MS * `BFSP_MS_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link
  bfsp_link_if.host link,
  // Host controls
  input wire logic accept_en,
  input wire logic time_pulse,
  input wire logic net_packet,
  // Bytes to send
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // Bytes received
  output logic [7:0] rx_data,
  output logic rx_valid
);
  localparam int CW = 24;
  localparam int STB = `BFSP_STROBE_CYC;
  logic [CW-1:0] rcnt;
  logic [3:0] ridx;
  logic [7:0] rsh;
  logic rbusy;
  logic [CW-1:0] ack_cnt;
  logic pending;
  // Receive, then pulse ready high for an acknowledge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rcnt <= '0;
      ridx <= 4'h0;
      rsh <= 8'h00;
      rbusy <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      ack_cnt <= '0;
      pending <= 1'b0;
      link.host_rx_ready_n <= 1'b1;
    end else begin
      rx_valid <= 1'b0;
      if (ack_cnt != '0) begin
        ack_cnt <= ack_cnt - CW'(1);
        link.host_rx_ready_n <= 1'b1;
      end else begin
        // Ready held low from wake until the byte is in
        link.host_rx_ready_n <= ~(accept_en || !link.dev_send_request_n || pending || rbusy);
      end
      if (!rbusy) begin
        if (!link.dev_tx) begin
          rbusy <= 1'b1;
          rcnt <= CW'(BIT_CYC / 2);
          ridx <= 4'h0;
        end
      end else if (rcnt == CW'(BIT_CYC - 1)) begin
        rcnt <= '0;
        ridx <= ridx + 4'h1;
        if (ridx >= 4'h1 && ridx <= 4'h8) begin
          rsh <= {link.dev_tx, rsh[7:1]};
        end
        if (ridx == 4'h9) begin
          rbusy <= 1'b0;
          rx_data <= rsh;
          rx_valid <= 1'b1;
          pending <= 1'b0;
          ack_cnt <= CW'(STB + 1);
        end
      end else begin
        rcnt <= rcnt + CW'(1);
      end
      if (!link.dev_send_request_n) begin
        pending <= 1'b1;
      end
    end
  end
  // Transmitter with packet gap and network-ready check
  logic [CW-1:0] tcnt;
  logic [3:0] tidx;
  logic [9:0] tsh;
  logic tbusy;
  logic tlast;
  logic [CW-1:0] gap;
  wire logic start_ok = gap == '0 && (!net_packet || !link.dev_net_ready_n);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tcnt <= '0;
      tidx <= 4'h0;
      tsh <= 10'h3ff;
      tbusy <= 1'b0;
      tlast <= 1'b0;
      gap <= '0;
      tx_ready <= 1'b0;
      link.host_tx <= 1'b1;
      link.time_strobe_n <= 1'b1;
      link.mode_byte_paced <= 1'b1;
    end else begin
      link.time_strobe_n <= ~time_pulse;
      link.mode_byte_paced <= 1'b1;
      tx_ready <= 1'b0;
      if (gap != '0) begin
        gap <= gap - CW'(1);
      end
      if (!tbusy) begin
        link.host_tx <= 1'b1;
        if (tx_valid && start_ok && !tx_ready) begin
          tx_ready <= 1'b1;
          tsh <= {1'b1, tx_data, 1'b0};
          tlast <= tx_last;
          tbusy <= 1'b1;
          tcnt <= '0;
          tidx <= 4'h0;
        end
      end else begin
        link.host_tx <= tsh[0];
        if (tcnt == CW'(BIT_CYC - 1)) begin
          tcnt <= '0;
          tsh <= {1'b1, tsh[9:1]};
          tidx <= tidx + 4'h1;
          if (tidx == 4'h9) begin
            tbusy <= 1'b0;
            gap <= tlast ? CW'(GAP_CYC) : '0;
          end
        end else begin
          tcnt <= tcnt + CW'(1);
        end
      end
    end
  end
endmodule

// >>> verif/bfsp_link_monitor.sv
// Link checker: assertions on the wires between the two ends.
// Assumes it sits beside the link interface, one clock domain.
`timescale 1ns/1ps
module bfsp_link_monitor #(
  parameter int BIT_CYC = 16,
  parameter int ACK_DELAY_CYC = 2000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link wires
  input wire logic dev_tx,
  input wire logic host_tx,
  input wire logic dev_send_request_n,
  input wire logic host_rx_ready_n,
  input wire logic dev_net_ready_n,
  input wire logic time_strobe_n
);
  localparam int ACK_LIM = ACK_DELAY_CYC + 4;
  int dev_low;
  int host_low;
  int rts_low;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Length of the current low run on the request line and on each data line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dev_low <= 0;
      host_low <= 0;
      rts_low <= 0;
    end else begin
      rts_low <= dev_send_request_n ? 0 : rts_low + 1;
      dev_low <= dev_tx ? 0 : dev_low + 1;
      host_low <= host_tx ? 0 : host_low + 1;
    end
  end
  // Wake request and byte pacing
  rts_release_a: assert property (
    !host_rx_ready_n && !dev_send_request_n |-> ##[1:4] dev_send_request_n)
    else $error("Request held after host ready");
  rts_timeout_a: assert property (rts_low <= ACK_LIM)
    else $error("Request held past timeout");
  start_bit_a: assert property (
    $rose(dev_send_request_n) && !host_rx_ready_n |-> ##[1:3] !dev_tx)
    else $error("Start bit late");
  tx_hold_a: assert property (host_rx_ready_n |-> dev_tx)
    else $error("Byte sent while host not ready");
  ack_pulse_a: assert property ($rose(host_rx_ready_n) |-> host_rx_ready_n [*5])
    else $error("Ready pulse too short");
  // Bit width and frame length on both data lines
  dev_bit_a: assert property ($rose(dev_tx) |-> dev_low % BIT_CYC == 0)
    else $error("Device bit width wrong");
  host_bit_a: assert property ($rose(host_tx) |-> host_low % BIT_CYC == 0)
    else $error("Host bit width wrong");
  dev_frame_a: assert property (dev_low <= 9 * BIT_CYC)
    else $error("Device stop bit missing");
  host_frame_a: assert property (host_low <= 9 * BIT_CYC)
    else $error("Host stop bit missing");
  // Main scenarios seen
  cover property ($fell(dev_send_request_n));
  cover property ($fell(dev_net_ready_n));
  cover property ($fell(time_strobe_n));
endmodule

// >>> verif/bfsp_tb_top.sv
// Testbench: device end and host end joined through the link interface.
// Assumes the design files compiled first; 10 MHz clock.
`timescale 1ns/1ps
module bfsp_tb_top;
  localparam int BIT = 16;
  localparam int ACK = 2000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] d_tx_data = 8'h00;
  logic d_tx_valid = 1'b0;
  logic d_tx_last = 1'b0;
  logic d_tx_ready, d_rx_valid, d_rx_frame_err, time_request, h_tx_ready, h_rx_valid;
  logic [7:0] d_rx_data, h_rx_data;
  logic net_joined = 1'b0;
  logic net_buf_free = 1'b0;
  logic accept_en = 1'b0;
  logic time_pulse = 1'b0;
  logic net_packet = 1'b0;
  logic [7:0] h_tx_data = 8'h00;
  logic h_tx_valid = 1'b0;
  logic h_tx_last = 1'b0;
  logic [31:0] seed = 32'h438f;
  int fail_count = 0;
  int compares = 0;
  int ts_count = 0;
  bfsp_pkg::bfsp_byte_t exp_h[$], exp_d[$], got_h[$], got_d[$];
  bfsp_link_if link();
  bfsp_device #(.BIT_CYC(BIT), .ACK_DELAY_CYC(ACK), .GAP_CYC(500)) bfsp_device_inst (
    .clock(clock), .rst(rst), .link(link.dev), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
    .tx_last(d_tx_last), .tx_ready(d_tx_ready), .rx_data(d_rx_data), .rx_valid(d_rx_valid),
    .rx_frame_err(d_rx_frame_err), .net_joined(net_joined), .net_buf_free(net_buf_free),
    .time_request(time_request));
  bfsp_host #(.BIT_CYC(BIT), .GAP_CYC(500)) bfsp_host_inst (
    .clock(clock), .rst(rst), .link(link.host), .accept_en(accept_en),
    .time_pulse(time_pulse), .net_packet(net_packet), .tx_data(h_tx_data),
    .tx_valid(h_tx_valid), .tx_last(h_tx_last), .tx_ready(h_tx_ready),
    .rx_data(h_rx_data), .rx_valid(h_rx_valid));
  bfsp_link_monitor #(.BIT_CYC(BIT), .ACK_DELAY_CYC(ACK)) bfsp_link_monitor_inst (
    .clock(clock), .rst(rst), .dev_tx(link.dev_tx), .host_tx(link.host_tx),
    .dev_send_request_n(link.dev_send_request_n), .host_rx_ready_n(link.host_rx_ready_n),
    .dev_net_ready_n(link.dev_net_ready_n), .time_strobe_n(link.time_strobe_n));
  // Clock
  always #50 clock = ~clock;
  // Collect received bytes and timestamp requests
  always @(negedge clock) begin
    if (h_rx_valid === 1'b1) got_h.push_back(h_rx_data);
    if (d_rx_valid === 1'b1) got_d.push_back(d_rx_data);
    if (time_request === 1'b1) ts_count++;
    if (d_rx_frame_err === 1'b1) chk(8'h1, 8'h0, "frame error");
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask
  task automatic dev_pkt(input int n, input logic [7:0] first);
    int w;
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      w = 0;
      b = (i == 0) ? first : rnd();
      exp_h.push_back(b);
      d_tx_data <= b;
      d_tx_valid <= 1'b1;
      d_tx_last <= (i == n - 1);
      do begin
        @(negedge clock);
        w++;
      end while (d_tx_ready !== 1'b1 && w < 8000);
      @(posedge clock);
    end
    d_tx_valid <= 1'b0;
  endtask
  task automatic host_pkt(input int n, input logic [7:0] first);
    int w;
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      w = 0;
      b = (i == 0) ? first : rnd();
      exp_d.push_back(b);
      h_tx_data <= b;
      h_tx_valid <= 1'b1;
      h_tx_last <= (i == n - 1);
      do begin
        @(negedge clock);
        w++;
      end while (h_tx_ready !== 1'b1 && w < 8000);
      @(posedge clock);
    end
    h_tx_valid <= 1'b0;
  endtask
  task automatic cmp_q(ref bfsp_pkg::bfsp_byte_t e[$], ref bfsp_pkg::bfsp_byte_t g[$]);
    int w;
    w = 0;
    while (g.size() < e.size() && w < 9000) begin
      @(negedge clock);
      w++;
    end
    chk(8'(g.size()), 8'(e.size()), "byte count");
    foreach (e[i]) if (i < g.size()) chk(g[i], e[i], "byte value");
    e.delete();
    g.delete();
    @(posedge clock);
  endtask
  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      net_joined <= i[0];
      net_buf_free <= i[1];
      repeat (4) @(posedge clock);
      chk({7'h0, link.dev_net_ready_n}, {7'h0, !(i[0] && i[1])}, "net ready");
    end
    $display("Net ready test done");
    fork
      dev_pkt(3, 8'h00);
      begin
        repeat (3) @(posedge clock);
        chk({7'h0, link.dev_send_request_n}, 8'h0, "no wake request");
        repeat (ACK + 50) @(posedge clock);
        chk({7'h0, link.dev_send_request_n}, 8'h1, "request kept");
        chk({7'h0, d_tx_ready}, 8'h0, "full buffer took byte");
        accept_en <= 1'b1;
      end
    join
    cmp_q(exp_h, got_h);
    $display("Timeout and buffer test done");
    net_buf_free <= 1'b0;
    net_packet <= 1'b1;
    repeat (600) @(posedge clock);
    fork
      dev_pkt(4, 8'hff);
      host_pkt(4, 8'h00);
      begin
        repeat (300) @(posedge clock);
        chk(8'(got_d.size()), 8'h0, "network packet not gated");
        net_buf_free <= 1'b1;
      end
    join
    cmp_q(exp_h, got_h);
    cmp_q(exp_d, got_d);
    net_buf_free <= 1'b0;
    net_packet <= 1'b0;
    repeat (600) @(posedge clock);
    host_pkt(3, rnd());
    cmp_q(exp_d, got_d);
    $display("Two-way traffic test done");
    for (int len = 5; len > 3; len--) begin
      ts_count = 0;
      time_pulse <= 1'b1;
      repeat (len) @(posedge clock);
      time_pulse <= 1'b0;
      repeat (20) @(posedge clock);
      chk(8'(ts_count), 8'(len >= 5), "timestamp request");
    end
    $display("Timestamp test done");
    end_of_test();
  end
endmodule
